// *** core/ckp_pkg.sv ***
package ckp_pkg;

    // Command decoded from the chip-select, row, column and write-enable pins.
    typedef enum logic [2:0] {
        CKP_CMD_NOP,
        CKP_CMD_ACT,
        CKP_CMD_RD,
        CKP_CMD_WR,
        CKP_CMD_PRE,
        CKP_CMD_REF,
        CKP_CMD_MRS,
        CKP_CMD_OTHER
    } ckp_cmd_t;

    // Power state as judged by this block.
    typedef enum logic [2:0] {
        CKP_ST_IDLE,
        CKP_ST_ACTIVE,
        CKP_ST_ACT_PD,
        CKP_ST_PRE_PD,
        CKP_ST_SELF_REF,
        CKP_ST_SR_EXIT
    } ckp_state_t;

    // Command pins sampled at one clock edge; cs_n, ras_n, cas_n and we_n are active low.
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic a10;
        logic [2:0] bank;
    } ckp_pins_t;

    // Status flags shown to the surrounding core.
    typedef struct packed {
        logic power_down;
        logic self_refresh;
        logic refresh_hold;
        logic read_ok;
        logic write_ok;
        logic odt_ok;
        logic illegal;
    } ckp_status_t;

    localparam int unsigned CKP_BANKS      = 8;
    localparam int unsigned CKP_BANK_W     = 3;
    localparam int unsigned CKP_CNT_W      = 10;

    // Clock period in picoseconds and the exit waits.
    localparam int unsigned CKP_CLK_PS     = 10000;
    localparam int unsigned CKP_TXS_NS     = 170;
    localparam int unsigned CKP_TXS_CYC    = (CKP_TXS_NS * 1000 + CKP_CLK_PS - 1) / CKP_CLK_PS;
    localparam int unsigned CKP_TXSDLL_NCK = 512;
    localparam int unsigned CKP_WR_NCK     = 512;

    localparam logic [CKP_CNT_W-1:0] CKP_TXS_CNT    = CKP_CNT_W'(CKP_TXS_CYC);
    localparam logic [CKP_CNT_W-1:0] CKP_TXSDLL_CNT = CKP_CNT_W'(CKP_TXSDLL_NCK);
    localparam logic [CKP_CNT_W-1:0] CKP_WR_CNT     = CKP_CNT_W'(CKP_WR_NCK);
    localparam logic [CKP_CNT_W-1:0] CKP_CNT_ZERO   = 10'h000;
    localparam logic [CKP_CNT_W-1:0] CKP_CNT_ONE    = 10'h001;
    localparam logic [CKP_BANKS-1:0] CKP_BANKS_NONE = 8'h00;
    localparam ckp_status_t           CKP_STATUS_RST = 7'h00;

endpackage : ckp_pkg

// *** core/ckp_decode.sv ***
// Decodes the command pins; deselect and NOP both come out as NOP.
module ckp_decode (
    input  wire ckp_pkg::ckp_pins_t pins_in,
    output ckp_pkg::ckp_cmd_t       cmd_out
);

    // Chip select high is a deselect, which behaves exactly like a NOP.
    always_comb begin
        if (pins_in.cs_n) begin
            cmd_out = ckp_pkg::CKP_CMD_NOP;
        end else begin
            unique case ({pins_in.ras_n, pins_in.cas_n, pins_in.we_n})
                3'h7:    cmd_out = ckp_pkg::CKP_CMD_NOP;
                3'h3:    cmd_out = ckp_pkg::CKP_CMD_ACT;
                3'h5:    cmd_out = ckp_pkg::CKP_CMD_RD;
                3'h4:    cmd_out = ckp_pkg::CKP_CMD_WR;
                3'h2:    cmd_out = ckp_pkg::CKP_CMD_PRE;
                3'h1:    cmd_out = ckp_pkg::CKP_CMD_REF;
                3'h0:    cmd_out = ckp_pkg::CKP_CMD_MRS;
                default: cmd_out = ckp_pkg::CKP_CMD_OTHER;
            endcase
        end
    end

endmodule : ckp_decode

// *** core/ckp_bank_track.sv ***
// Tracks which banks hold an open row, one flag per bank.
module ckp_bank_track (
    input  wire logic                               ref_clk_in,
    input  wire logic                               rst_in,
    input  wire logic                               ce_in,
    input  wire logic                               take_in,
    input  wire ckp_pkg::ckp_cmd_t                  cmd_in,
    input  wire logic                               all_in,
    input  wire logic [ckp_pkg::CKP_BANK_W-1:0]     bank_in,
    output logic      [ckp_pkg::CKP_BANKS-1:0]      open_out
);

    logic [ckp_pkg::CKP_BANKS-1:0] next_open;

    genvar gi;
    generate
        for (gi = 0; gi < ckp_pkg::CKP_BANKS; gi++) begin : g_bank
            // Activate opens a bank; precharge closes it, or all when A10 is high.
            always_comb begin
                next_open[gi] = open_out[gi];
                if (take_in && cmd_in == ckp_pkg::CKP_CMD_ACT
                    && bank_in == ckp_pkg::CKP_BANK_W'(gi)) begin
                    next_open[gi] = 1'b1;
                end else if (take_in && cmd_in == ckp_pkg::CKP_CMD_PRE
                    && (all_in || bank_in == ckp_pkg::CKP_BANK_W'(gi))) begin
                    next_open[gi] = 1'b0;
                end
            end
        end
    endgenerate

    // Registers the bank flags.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            open_out <= ckp_pkg::CKP_BANKS_NONE;
        end else if (ce_in) begin
            open_out <= next_open;
        end
    end

endmodule : ckp_bank_track

// *** core/ckp_power_ctrl.sv ***
// Contract
// [R1] Act on previous CKE, current CKE, command.
// [R2] Current state is state before edge.
// [R3] Controller waits mode-register delays before CKE low.
// [R4] Controller holds CKE level for minimum pulse.
// [R5] Only NOP or deselect at power-down edges.
// [R6] Only NOP or deselect at self-refresh exit.
// [R7] Only NOP during exit period, reads wait.
// [R8] No read or ODT before DLL-lock delay.
// [R9] First write waits 512 cycles after exit.
// [R10] Self refresh from idle by refresh, CKE falling.
// [R11] Controller never enters self refresh mid-burst.
// [R12] Power-down type follows open banks after access.
// [R13] Open banks plus CKE fall: active power-down.
// [R14] Idle banks plus CKE fall: precharge power-down.
// [R15] No refresh during power-down.
// [R16] CKE low holds state, ignores commands.
// [R17] ODT unavailable in self refresh, no effect.
// [R18] Idle needs banks closed, exits met.
// [R19] Undefined CKE sequences are illegal.
// [R20] Other states take only legal commands.
// [R21] Self-refresh exit on CKE rise, unclocked; here exit is taken at an enabled clock edge that sees CKE high.
// [R22] Deselect equals NOP, never ends bursts.
// [R23] Power-down exit returns to previous state.
module ckp_power_ctrl (
    input  wire logic                 ref_clk_in,
    input  wire logic                 rst_in,
    input  wire logic                 ce_in,
    input  wire logic                 cke_in,
    input  wire ckp_pkg::ckp_pins_t   pins_in,
    input  wire logic                 odt_in,
    input  wire logic                 burst_busy_in,
    output ckp_pkg::ckp_state_t       state_out,
    output ckp_pkg::ckp_status_t      status_out,
    output logic                      odt_en_out,
    output logic                      cmd_take_out
);

    ckp_pkg::ckp_cmd_t             cmd;
    logic [ckp_pkg::CKP_BANKS-1:0] banks_open;
    logic                          cke_prev;
    logic                          next_cke_prev;
    logic                          take;
    logic                          next_take;
    logic                          odt_en;
    logic                          next_odt_en;
    logic [ckp_pkg::CKP_CNT_W-1:0] xs_cnt;
    logic [ckp_pkg::CKP_CNT_W-1:0] next_xs_cnt;
    logic [ckp_pkg::CKP_CNT_W-1:0] dll_cnt;
    logic [ckp_pkg::CKP_CNT_W-1:0] next_dll_cnt;
    logic [ckp_pkg::CKP_CNT_W-1:0] wr_cnt;
    logic [ckp_pkg::CKP_CNT_W-1:0] next_wr_cnt;
    ckp_pkg::ckp_state_t           state;
    ckp_pkg::ckp_state_t           next_state;
    ckp_pkg::ckp_state_t           pd_return;
    ckp_pkg::ckp_state_t           next_pd_return;
    ckp_pkg::ckp_status_t          status;
    ckp_pkg::ckp_status_t          next_status;
    logic                          cmd_nop;
    logic                          cke_fall;
    logic                          cke_rise;

    ckp_decode u_decode (
        .pins_in (pins_in),
        .cmd_out (cmd)
    );

    // Banks only follow commands taken while the clock is enabled and CKE was high.
    ckp_bank_track u_banks (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .take_in    (take),
        .cmd_in     (cmd),
        .all_in     (pins_in.a10),
        .bank_in    (pins_in.bank),
        .open_out   (banks_open)
    );

    // [R22] deselect equals NOP
    assign cmd_nop  = (cmd == ckp_pkg::CKP_CMD_NOP);
    // [R1] edge pair sampled
    assign cke_fall = cke_prev && !cke_in;
    assign cke_rise = !cke_prev && cke_in;

    // [R16] commands ignored low
    always_comb begin
        take = cke_prev && cke_in && !cmd_nop
               && (state == ckp_pkg::CKP_ST_IDLE || state == ckp_pkg::CKP_ST_ACTIVE);
    end

    // Main power-state decision, made from the state held before this edge.
    always_comb begin
        next_state     = state;
        next_pd_return = pd_return;
        next_cke_prev  = cke_in;
        next_take      = take;
        next_status    = status;
        next_status.illegal = 1'b0;
        // [R2] state before edge
        unique case (state)
            ckp_pkg::CKP_ST_IDLE, ckp_pkg::CKP_ST_ACTIVE: begin
                if (cke_fall) begin
                    // [R10] self-refresh entry
                    if (cmd == ckp_pkg::CKP_CMD_REF && state == ckp_pkg::CKP_ST_IDLE
                        && banks_open == ckp_pkg::CKP_BANKS_NONE && !burst_busy_in) begin
                        next_state = ckp_pkg::CKP_ST_SELF_REF;
                    end else if (cmd_nop) begin
                        // [R12] type by open banks
                        if (banks_open != ckp_pkg::CKP_BANKS_NONE) begin
                            // [R13] active power-down
                            next_state     = ckp_pkg::CKP_ST_ACT_PD;
                            next_pd_return = ckp_pkg::CKP_ST_ACTIVE;
                        end else begin
                            // [R14] precharge power-down
                            next_state     = ckp_pkg::CKP_ST_PRE_PD;
                            next_pd_return = ckp_pkg::CKP_ST_IDLE;
                        end
                    end else begin
                        // [R19] illegal sequence flagged
                        next_status.illegal = 1'b1;
                    end
                end else if (cke_in && cmd == ckp_pkg::CKP_CMD_OTHER) begin
                    // [R20] illegal command flagged
                    next_status.illegal = 1'b1;
                end else begin
                    // [R18] idle needs banks closed
                    next_state = (banks_open != ckp_pkg::CKP_BANKS_NONE || burst_busy_in)
                                 ? ckp_pkg::CKP_ST_ACTIVE : ckp_pkg::CKP_ST_IDLE;
                end
            end
            ckp_pkg::CKP_ST_ACT_PD, ckp_pkg::CKP_ST_PRE_PD: begin
                if (cke_rise) begin
                    // [R23] return to prior state
                    next_state = pd_return;
                    next_status.illegal = !cmd_nop;
                end
            end
            ckp_pkg::CKP_ST_SELF_REF: begin
                // [R21] exit on CKE level
                if (cke_in) begin
                    next_state = ckp_pkg::CKP_ST_SR_EXIT;
                    next_status.illegal = !cmd_nop;
                end
            end
            ckp_pkg::CKP_ST_SR_EXIT: begin
                // [R7] wait out exit period
                if (xs_cnt == ckp_pkg::CKP_CNT_ZERO) begin
                    next_state = ckp_pkg::CKP_ST_IDLE;
                end else if (!cmd_nop) begin
                    next_status.illegal = 1'b1;
                end
            end
        endcase
        // [R15] no refresh in power-down
        next_status.power_down   = (next_state == ckp_pkg::CKP_ST_ACT_PD)
                                   || (next_state == ckp_pkg::CKP_ST_PRE_PD);
        next_status.refresh_hold = next_status.power_down;
        next_status.self_refresh = (next_state == ckp_pkg::CKP_ST_SELF_REF);
        // [R8] reads wait for lock
        next_status.read_ok  = (next_state == ckp_pkg::CKP_ST_IDLE
                                || next_state == ckp_pkg::CKP_ST_ACTIVE)
                               && (next_dll_cnt == ckp_pkg::CKP_CNT_ZERO);
        next_status.odt_ok   = next_status.read_ok;
        // [R9] writes wait 512 cycles
        next_status.write_ok = (next_state == ckp_pkg::CKP_ST_IDLE
                                || next_state == ckp_pkg::CKP_ST_ACTIVE)
                               && (next_wr_cnt == ckp_pkg::CKP_CNT_ZERO);
    end

    // Exit counters restart on leaving self refresh and count down to zero.
    always_comb begin
        next_xs_cnt  = xs_cnt;
        next_dll_cnt = dll_cnt;
        next_wr_cnt  = wr_cnt;
        if (state == ckp_pkg::CKP_ST_SELF_REF && cke_in) begin
            next_xs_cnt  = ckp_pkg::CKP_TXS_CNT;
            next_dll_cnt = ckp_pkg::CKP_TXSDLL_CNT;
            next_wr_cnt  = ckp_pkg::CKP_WR_CNT;
        end else begin
            if (xs_cnt != ckp_pkg::CKP_CNT_ZERO) begin
                next_xs_cnt = xs_cnt - ckp_pkg::CKP_CNT_ONE;
            end
            if (dll_cnt != ckp_pkg::CKP_CNT_ZERO) begin
                next_dll_cnt = dll_cnt - ckp_pkg::CKP_CNT_ONE;
            end
            if (wr_cnt != ckp_pkg::CKP_CNT_ZERO) begin
                next_wr_cnt = wr_cnt - ckp_pkg::CKP_CNT_ONE;
            end
        end
    end

    // [R17] termination off in self refresh
    always_comb begin
        next_odt_en = odt_in && next_status.odt_ok && !next_status.self_refresh;
    end

    // Registers all state; the clock enable freezes everything.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state        <= ckp_pkg::CKP_ST_IDLE;
            pd_return    <= ckp_pkg::CKP_ST_IDLE;
            cke_prev     <= 1'b0;
            cmd_take_out <= 1'b0;
            odt_en       <= 1'b0;
            xs_cnt       <= ckp_pkg::CKP_CNT_ZERO;
            dll_cnt      <= ckp_pkg::CKP_CNT_ZERO;
            wr_cnt       <= ckp_pkg::CKP_CNT_ZERO;
            status       <= ckp_pkg::CKP_STATUS_RST;
        end else if (ce_in) begin
            state        <= next_state;
            pd_return    <= next_pd_return;
            cke_prev     <= next_cke_prev;
            cmd_take_out <= next_take;
            odt_en       <= next_odt_en;
            xs_cnt       <= next_xs_cnt;
            dll_cnt      <= next_dll_cnt;
            wr_cnt       <= next_wr_cnt;
            status       <= next_status;
        end
    end

    assign state_out  = state;
    assign status_out = status;
    assign odt_en_out = odt_en;

endmodule : ckp_power_ctrl

// *** verification/ckp_ctrl_model.sv ***
module ckp_ctrl_model (
    input  wire logic          ref_clk_in,
    output logic               cke_out,
    output ckp_pkg::ckp_pins_t pins_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Start deselected with CKE high, as a controller does after power-up.
    initial begin
        cke_out  = 1'b1;
        pins_out = 8'hFF;
    end

    // Deselected lines float, so they toggle each edge rather than keep a value.
    // Deselect at transitions.
    task automatic issue(input logic cke, input logic [3:0] cmd, input logic a10);
        @(negedge ref_clk_in);
        cke_out = cke;
        if (cmd[3]) begin
            pins_out = {1'b1, ~pins_out[6:0]};
        end else begin
            pins_out = {cmd, a10, 3'h5};
        end
    endtask : issue

endmodule : ckp_ctrl_model

// *** verification/ckp_power_monitor.sv ***
module ckp_power_monitor (
    input wire logic                ref_clk_in,
    input wire logic                rst_in,
    input wire logic                ce_in,
    input wire logic                cke_in,
    input wire ckp_pkg::ckp_pins_t  pins_in,
    input wire logic                odt_in,
    input wire logic                burst_busy_in,
    input wire ckp_pkg::ckp_state_t state_out,
    input wire ckp_pkg::ckp_status_t status_out,
    input wire logic                odt_en_out,
    input wire logic                cmd_take_out
);
    logic       cke_prev, next_cke_prev, seen_sr, next_seen_sr;
    logic [9:0] sr_cnt, next_sr_cnt;
    logic [4:0] exit_cnt, next_exit_cnt;
    wire quiet = pins_in.cs_n | (pins_in.ras_n & pins_in.cas_n & pins_in.we_n);
    wire is_ref = ~pins_in.cs_n & ~pins_in.ras_n & ~pins_in.cas_n & pins_in.we_n;
    wire fall = ce_in & cke_prev & ~cke_in;
    wire rise = ce_in & ~cke_prev & cke_in;
    wire in_pd = state_out inside {ckp_pkg::CKP_ST_ACT_PD, ckp_pkg::CKP_ST_PRE_PD};

    // Counters run only on enabled edges, because the block freezes otherwise.
    always_comb begin
        next_cke_prev = ce_in ? cke_in : cke_prev;
        next_seen_sr  = seen_sr | (state_out == ckp_pkg::CKP_ST_SELF_REF);
        next_sr_cnt   = sr_cnt;
        next_exit_cnt = 5'h00;
        if (state_out == ckp_pkg::CKP_ST_SELF_REF) begin
            next_sr_cnt = 10'h000;
        end else if (ce_in && sr_cnt != 10'h3FF) begin
            next_sr_cnt = sr_cnt + 10'h001;
        end
        if (state_out == ckp_pkg::CKP_ST_SR_EXIT) begin
            next_exit_cnt = ce_in ? exit_cnt + 5'h01 : exit_cnt;
        end
    end

    // Helper registers.
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cke_prev <= 1'b0;
            seen_sr  <= 1'b0;
            sr_cnt   <= 10'h000;
            exit_cnt <= 5'h00;
        end else begin
            cke_prev <= next_cke_prev;
            seen_sr  <= next_seen_sr;
            sr_cnt   <= next_sr_cnt;
            exit_cnt <= next_exit_cnt;
        end
    end

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // The state lags the bank flags by one edge after a taken command, so those edges are skipped.
    a_low_hold: assert property (
        ce_in && !cke_prev && !cke_in && (in_pd || state_out == ckp_pkg::CKP_ST_SELF_REF)
        |=> $stable(state_out)) else $error("state moved with CKE low");
    a_pre_pd: assert property (
        fall && quiet && !cmd_take_out && state_out == ckp_pkg::CKP_ST_IDLE
        |=> state_out == ckp_pkg::CKP_ST_PRE_PD) else $error("no precharge power-down");
    a_act_pd: assert property (
        fall && quiet && !burst_busy_in && !$past(burst_busy_in) && !cmd_take_out
        && state_out == ckp_pkg::CKP_ST_ACTIVE
        |=> state_out == ckp_pkg::CKP_ST_ACT_PD) else $error("no active power-down");
    a_sr_entry: assert property (
        fall && is_ref && !burst_busy_in && !cmd_take_out && state_out == ckp_pkg::CKP_ST_IDLE
        |=> state_out == ckp_pkg::CKP_ST_SELF_REF) else $error("no self refresh");
    a_sr_exit: assert property (
        rise && state_out == ckp_pkg::CKP_ST_SELF_REF
        |=> state_out == ckp_pkg::CKP_ST_SR_EXIT) else $error("no exit");
    a_exit_len: assert property (
        ce_in && exit_cnt == 5'h11 && state_out == ckp_pkg::CKP_ST_SR_EXIT
        |=> state_out == ckp_pkg::CKP_ST_IDLE) else $error("exit wait wrong");
    a_exit_stay: assert property (
        ce_in && exit_cnt < 5'h11 && state_out == ckp_pkg::CKP_ST_SR_EXIT
        |=> state_out == ckp_pkg::CKP_ST_SR_EXIT) else $error("exit wait cut short");
    a_pd_return: assert property (
        rise && state_out == ckp_pkg::CKP_ST_PRE_PD
        |=> state_out == ckp_pkg::CKP_ST_IDLE) else $error("no return to idle");
    a_exit_flag: assert property (
        rise && in_pd && !quiet
        |=> status_out.illegal) else $error("bad exit command not flagged");
    a_sr_no_odt: assert property (
        state_out == ckp_pkg::CKP_ST_SELF_REF && $past(state_out) == ckp_pkg::CKP_ST_SELF_REF
        |-> !odt_en_out) else $error("termination in self refresh");
    a_read_wait: assert property (
        seen_sr && sr_cnt < 10'h200 && state_out != ckp_pkg::CKP_ST_SELF_REF
        |-> !status_out.read_ok && !status_out.write_ok) else $error("access allowed early");
    a_take_pulse: assert property (
        ce_in && cke_prev && cke_in && !quiet
        && (state_out == ckp_pkg::CKP_ST_IDLE || state_out == ckp_pkg::CKP_ST_ACTIVE)
        |=> cmd_take_out) else $error("command not taken");
    a_low_ignore: assert property (
        ce_in && !cke_in |=> !cmd_take_out) else $error("command taken with CKE low");

    c_sr_entry: cover property (fall && is_ref && state_out == ckp_pkg::CKP_ST_IDLE);
    c_act_pd: cover property (state_out == ckp_pkg::CKP_ST_ACT_PD);
    c_pd_exit: cover property (rise && state_out == ckp_pkg::CKP_ST_PRE_PD);

endmodule : ckp_power_monitor

bind ckp_power_ctrl ckp_power_monitor u_ckp_power_monitor (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .ce_in(ce_in), .cke_in(cke_in), .pins_in(pins_in), .odt_in(odt_in),
    .burst_busy_in(burst_busy_in), .state_out(state_out), .status_out(status_out),
    .odt_en_out(odt_en_out), .cmd_take_out(cmd_take_out));

// *** verification/sdram_cke_power_state_control_bench.sv ***
module sdram_cke_power_state_control_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam ckp_pkg::ckp_state_t S_ID = ckp_pkg::CKP_ST_IDLE;
    localparam ckp_pkg::ckp_state_t S_AC = ckp_pkg::CKP_ST_ACTIVE;
    localparam ckp_pkg::ckp_state_t S_AP = ckp_pkg::CKP_ST_ACT_PD;
    localparam ckp_pkg::ckp_state_t S_PP = ckp_pkg::CKP_ST_PRE_PD;
    localparam ckp_pkg::ckp_state_t S_SR = ckp_pkg::CKP_ST_SELF_REF;
    localparam ckp_pkg::ckp_state_t S_SX = ckp_pkg::CKP_ST_SR_EXIT;
    localparam logic [3:0] NOP = 4'h7, DES = 4'h8, ACT = 4'h3, REF = 4'h1, PRE = 4'h2, RD = 4'h5;

    logic                 ref_clk_in = 1'b0;
    logic                 rst_in = 1'b1;
    logic                 ce = 1'b1;
    logic                 odt = 1'b0;
    logic                 busy = 1'b0;
    logic                 cke, odt_en, take;
    ckp_pkg::ckp_pins_t   pins;
    ckp_pkg::ckp_state_t  state;
    ckp_pkg::ckp_status_t status;
    logic [4:0]           notes[$];
    logic [4:0]           note;
    logic [3:0]           flags;
    logic                 pd_e;
    logic                 sr_e;
    logic [31:0]          seed = 32'h0000001E;
    logic [31:0]          r;
    int                   n_mismatch = 0;
    int                   samples_checked = 0;
    int                   cycles = 0;

    always #5 ref_clk_in = ~ref_clk_in;

    ckp_ctrl_model u_ckp_ctrl_model (.ref_clk_in(ref_clk_in), .cke_out(cke), .pins_out(pins));

    ckp_power_ctrl u_ckp_power_ctrl (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce),
        .cke_in(cke), .pins_in(pins), .odt_in(odt), .burst_busy_in(busy), .state_out(state),
        .status_out(status), .odt_en_out(odt_en), .cmd_take_out(take));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One edge of traffic; side carries clock enable, termination and burst busy.
    task automatic step(input logic k, input logic [3:0] c, input logic a10,
                        input logic [2:0] side, input logic care,
                        input ckp_pkg::ckp_state_t st, input logic ill);
        u_ckp_ctrl_model.issue(k, c, a10);
        {ce, odt, busy} = side;
        notes.push_back({care, st, ill});
    endtask : step

    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // The watcher takes the oldest note once the edge's updates have landed.
    always @(posedge ref_clk_in) begin
        if (notes.size() != 0) begin
            #1;
            note = notes.pop_front();
            if (note[4]) begin
                pd_e  = (note[3:1] == S_AP) || (note[3:1] == S_PP);
                sr_e  = (note[3:1] == S_SR);
                flags = {1'b0, status.refresh_hold, status.power_down, status.self_refresh};
                check({state, status.illegal}, note[3:0]);
                check(flags, {1'b0, pd_e, pd_e, sr_e});
            end
        end
    end

    // The run needs under 700 cycles, so 5000 only trips on a hang.
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            finish_test();
        end
    end

    // Power-down, enable freeze, active power-down, bad exit, self refresh.
    // No mode-register set is sent, so CKE may fall at any time.
    // Away from CKE edges and exit waits only decoded commands go out.
    initial begin
        repeat (5) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        rst_in = 1'b0;
        repeat (2) step(1, NOP, 0, 3'h4, 1, S_ID, 0);
        step(0, DES, 0, 3'h4, 1, S_PP, 0);
        repeat (4) begin
            r = xs();
            step(0, r[3:0], r[4], {1'b1, r[6:5]}, 1, S_PP, 0);
        end
        repeat (2) step(1, DES, 0, 3'h0, 1, S_PP, 0);
        step(1, DES, 0, 3'h4, 1, S_ID, 0);
        step(1, ACT, 0, 3'h4, 0, S_ID, 0);
        repeat (2) step(1, NOP, 0, 3'h4, 1, S_AC, 0);
        step(0, NOP, 0, 3'h4, 1, S_AP, 0);
        repeat (3) step(0, DES, 0, 3'h4, 1, S_AP, 0);
        repeat (2) step(1, NOP, 0, 3'h4, 1, S_AC, 0);
        step(1, PRE, 1, 3'h4, 0, S_ID, 0);
        repeat (2) step(1, NOP, 0, 3'h4, 1, S_ID, 0);
        step(0, NOP, 0, 3'h4, 1, S_PP, 0);
        repeat (3) step(0, DES, 0, 3'h4, 1, S_PP, 0);
        step(1, RD, 0, 3'h4, 1, S_ID, 1);
        repeat (3) step(1, NOP, 0, 3'h4, 1, S_ID, 0);
        step(0, REF, 0, 3'h4, 1, S_SR, 0);
        repeat (4) begin
            r = xs();
            step(0, r[3:0], r[4], {1'b1, r[6:5]}, 1, S_SR, 0);
        end
        step(1, DES, 0, 3'h4, 1, S_SX, 0);
        repeat (17) step(1, NOP, 0, 3'h4, 1, S_SX, 0);
        repeat (500) step(1, NOP, 0, 3'h4, 1, S_ID, 0);
        // Outside the CKE-low stretches, termination is only requested once the lock wait has surely run out.
        repeat (20) step(1, NOP, 0, 3'h6, 1, S_ID, 0);
        wait (notes.size() == 0);
        @(negedge ref_clk_in);
        check({status.read_ok, status.write_ok, status.odt_ok, odt_en}, 4'hF);
        finish_test();
    end

endmodule : sdram_cke_power_state_control_bench
